// File: verilog/bgw_pkg.sv
`default_nettype none
package bgw_pkg;
	// clock and long timings
	localparam longint CLK_HZ = 100_000_000;
	localparam longint AVG_SETTLE_S = 60;
	localparam longint AVG_SETTLE_CNT = AVG_SETTLE_S * CLK_HZ;
	localparam int SETTLE_W = 33;
	// smbus slave address, arbitrary default
	localparam logic [6:0] SLAVE_ADDR = 7'h0b;
	// command codes of the readable words
	localparam logic [7:0] CMD_RATE_TTF = 8'h05;
	localparam logic [7:0] CMD_RATE_TTE = 8'h06;
	localparam logic [7:0] CMD_RATE_OK = 8'h07;
	localparam logic [7:0] CMD_TEMP = 8'h08;
	localparam logic [7:0] CMD_VOLT = 8'h09;
	localparam logic [7:0] CMD_CURR = 8'h0a;
	localparam logic [7:0] CMD_MEAN_CURR = 8'h0b;
	localparam logic [7:0] CMD_ERR_PCT = 8'h0c;
	localparam logic [7:0] CMD_PCT_FULL = 8'h0d;
	localparam logic [7:0] CMD_PCT_DESIGN = 8'h0e;
	localparam logic [7:0] CMD_CAP_LEFT = 8'h0f;
	localparam logic [7:0] CMD_CAP_FULL = 8'h10;
	localparam logic [7:0] CMD_TTE_NOW = 8'h11;
	localparam logic [7:0] CMD_TTE_AVG = 8'h12;
	localparam logic [7:0] CMD_TTF_AVG = 8'h13;
	localparam logic [7:0] CMD_CHG_CURR = 8'h14;
	localparam logic [7:0] CMD_CHG_VOLT = 8'h15;
	localparam logic [7:0] CMD_STATUS = 8'h16;
	localparam logic [7:0] CMD_CYCLES = 8'h17;
	// special values and limits
	localparam logic [15:0] WORD_INVALID = 16'hffff;
	localparam logic [15:0] WORD_TRUE = 16'h0001;
	localparam logic [15:0] WORD_ZERO = 16'h0000;
	localparam logic [15:0] PCT_MAX = 16'h0064;
	localparam logic [15:0] CAP_LOW_MAH = 16'h05e0;
	localparam logic [15:0] CAP_HIGH_MAH = 16'h28a0;
	localparam logic [7:0] CYCLE_DROP_PCT = 8'h0f;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] LAST_BIT = 4'h7;
	localparam logic [2:0] IDX_ADDR_WR = 3'h0;
	localparam logic [2:0] IDX_CMD = 3'h1;
	localparam logic [2:0] IDX_ADDR_RD = 3'h2;
	localparam logic [2:0] IDX_LOW = 3'h3;
	localparam logic [2:0] IDX_HIGH = 3'h4;
	// raw figures from the gauge arithmetic
	typedef struct packed {
		logic [15:0] target_rate;
		logic [15:0] rate_ttf;
		logic [15:0] rate_tte;
		logic [15:0] temperature;
		logic [15:0] voltage;
		logic [15:0] current;
		logic [15:0] mean_current;
		logic [15:0] error_pct;
		logic [15:0] pct_full;
		logic [15:0] pct_design;
		logic [15:0] capacity_left;
		logic [15:0] eeprom_full_cap;
		logic [15:0] tte_now;
		logic [15:0] tte_avg;
		logic [15:0] ttf_avg;
		logic [15:0] chg_current;
		logic [15:0] chg_voltage;
	} bgw_raw_t;
	// alarm and status word, msb first
	typedef struct packed {
		logic over_charged;
		logic term_charge;
		logic rsvd_13;
		logic over_temp;
		logic term_discharge;
		logic rsvd_10;
		logic low_capacity;
		logic low_time;
		logic initialized;
		logic discharging;
		logic fully_charged;
		logic fully_discharged;
		logic [3:0] error_code;
	} bgw_status_t;
	// internal flag sources
	typedef struct packed {
		logic display_select_flag;
		logic protector_state_flag;
		logic cell_type_flag;
		logic termination_capacity_flag;
		logic high_pack_voltage_flag;
		logic cold_fault_flag;
		logic excess_charge_current_flag;
		logic temp_rate_term_flag;
		logic taper_term_flag;
		logic charge_qualify_flag;
		logic discharge_qualify_flag;
		logic overload_flag;
		logic first_end_discharge_flag;
		logic final_end_discharge_flag;
	} bgw_flags_t;
	typedef enum logic [2:0] {PH_IDLE, PH_RX, PH_SLV_ACK, PH_TX, PH_HOST_ACK} bgw_phase_t;
	// whole state of the readout block
	typedef struct packed {
		logic scl_m;
		logic scl_s;
		logic scl_q;
		logic sda_m;
		logic sda_s;
		logic sda_q;
		bgw_phase_t phase;
		logic [2:0] idx;
		logic [3:0] cnt;
		logic [7:0] shreg;
		logic drive;
		logic mack;
		logic cmd_ok;
		logic [15:0] word;
		logic [SETTLE_W-1:0] up_cnt;
		logic avg_ok;
		logic learned;
		logic [15:0] learned_cap;
		logic cap_store;
		logic [15:0] cycles;
		logic [7:0] base_pct;
		logic armed;
		logic cyc_store;
		logic [15:0] last_ichg;
		logic [15:0] last_vchg;
		logic chg_send;
		logic [7:0] upper;
		logic [7:0] lower;
		logic pct_valid;
	} bgw_state_t;
endpackage
`default_nettype wire

// File: verilog/bgw_readout.sv
// Contract
// R1: host sets signed milliamp target rate before reading at-rate predictions.
// R2: 0x05 gives at-rate minutes to full; 65535 when rate negative.
// R3: 0x06 gives at-rate minutes to empty; 65535 when rate not negative.
// R4: 0x07 reads zero when final end-of-discharge flag set, else nonzero.
// R5: 0x08 gives pack temperature in tenths of kelvin.
// R6: 0x09 gives pack voltage in millivolts.
// R7: 0x0a gives signed instantaneous current, positive charging.
// R8: 0x0b gives signed mean current, meaningful after first minute.
// R9: 0x0c gives estimate error percentage 0 to 100.
// R10: 0x0d gives percent of full capacity, valid for bounded pack capacity.
// R11: 0x0e gives percent of design capacity, may exceed 100.
// R12: 0x0f gives remaining capacity in milliamp-hours.
// R13: 0x10 gives eeprom capacity until learned; learned value stored promptly.
// R14: 0x11 gives minutes to empty now; 65535 when not discharging.
// R15: 0x12 gives averaged minutes to empty; 65535 when not discharging.
// R16: 0x13 gives averaged minutes to full; 65535 when not charging.
// R17: 0x14 gives charge current request; sent to charger when broadcasting.
// R18: 0x15 gives charge voltage request; sent to charger when broadcasting.
// R19: status word alarm bits at fixed positions, two reserved bits zero.
// R20: status word state bits, low nibble carries error code.
// R21: count a cycle during charge after 15 percent drop below last charge.
// R22: cycle count update stored promptly, count saturates at 65535.
// R23: upper and lower flag bytes follow the fixed bit layout.
// R24: words return by smbus read-word, low byte first; unknown codes nacked.
`default_nettype none
module bgw_readout
	import bgw_pkg::*;
#(
	parameter logic [SETTLE_W-1:0] AVG_SETTLE_CYCLES = SETTLE_W'(AVG_SETTLE_CNT)
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// smbus pins
	input wire logic smbc_in,
	input wire logic smbd_in,
	output logic smbd_out,
	output logic smbd_oe,
	// gauge figures and flags
	input wire bgw_raw_t raw,
	input wire bgw_status_t status_in,
	input wire bgw_flags_t flags_in,
	// capacity learning and eeprom
	input wire logic learn_valid,
	input wire logic [15:0] learn_value,
	input wire logic ee_cycle_load,
	input wire logic [15:0] ee_cycle_value,
	input wire logic charge_end,
	output logic ee_capacity_store,
	output logic ee_cycle_store,
	output logic [15:0] capacity_when_full,
	output logic [15:0] cycle_counter,
	// charger broadcast
	input wire logic broadcast_enable,
	output logic charger_send,
	output logic [15:0] charger_current,
	output logic [15:0] charger_voltage,
	// flag bytes and validity
	output logic [7:0] upper_flag_byte,
	output logic [7:0] lower_flag_byte,
	output logic pct_valid,
	output logic mean_current_valid
);
	bgw_state_t s;
	bgw_state_t next_s;
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	logic cmd_known;
	logic [15:0] cmd_word;
	logic [15:0] cap_full;
	logic [15:0] st_word;
	logic rate_neg;
	logic discharging;
	logic charging;
	logic [8:0] drop_level;
	logic [8:0] base_level;

	// pin edges seen through the second sync stage
	assign scl_rise = s.scl_s & ~s.scl_q;
	assign scl_fall = ~s.scl_s & s.scl_q;
	assign bus_start = s.scl_s & s.scl_q & s.sda_q & ~s.sda_s;
	assign bus_stop = s.scl_s & s.scl_q & ~s.sda_q & s.sda_s;

	// sign of the host rate and of the measured current
	assign rate_neg = raw.target_rate[15]; // R1
	assign discharging = raw.current[15];
	assign charging = ~raw.current[15] & (raw.current != WORD_ZERO);
	assign cap_full = s.learned ? s.learned_cap : raw.eeprom_full_cap; // R13
	assign st_word = {status_in.over_charged, status_in.term_charge, 1'b0, // R19
		status_in.over_temp, status_in.term_discharge, 1'b0,
		status_in.low_capacity, status_in.low_time,
		status_in.initialized, status_in.discharging, // R20
		status_in.fully_charged, status_in.fully_discharged,
		status_in.error_code};

	// nine-bit levels so a high percentage cannot wrap below the base
	assign drop_level = {1'b0, raw.pct_full[7:0]} + {1'b0, CYCLE_DROP_PCT};
	assign base_level = {1'b0, s.base_pct};

	// command decode to the word to return
	always_comb begin
		cmd_known = 1'b1;
		cmd_word = WORD_ZERO;
		unique case (s.shreg)
			CMD_RATE_TTF: begin
				cmd_word = rate_neg ? WORD_INVALID : raw.rate_ttf; // R2
			end
			CMD_RATE_TTE: begin
				cmd_word = rate_neg ? raw.rate_tte : WORD_INVALID; // R3
			end
			CMD_RATE_OK: begin
				cmd_word = flags_in.final_end_discharge_flag ? WORD_ZERO : WORD_TRUE; // R4
			end
			CMD_TEMP: begin
				cmd_word = raw.temperature; // R5
			end
			CMD_VOLT: begin
				cmd_word = raw.voltage; // R6
			end
			CMD_CURR: begin
				cmd_word = raw.current; // R7
			end
			CMD_MEAN_CURR: begin
				cmd_word = s.avg_ok ? raw.mean_current : WORD_ZERO; // R8
			end
			CMD_ERR_PCT: begin
				cmd_word = (raw.error_pct > PCT_MAX) ? PCT_MAX : raw.error_pct; // R9
			end
			CMD_PCT_FULL: begin
				cmd_word = (raw.pct_full > PCT_MAX) ? PCT_MAX : raw.pct_full; // R10
			end
			CMD_PCT_DESIGN: begin
				cmd_word = raw.pct_design; // R11
			end
			CMD_CAP_LEFT: begin
				cmd_word = raw.capacity_left; // R12
			end
			CMD_CAP_FULL: begin
				cmd_word = cap_full; // R13
			end
			CMD_TTE_NOW: begin
				cmd_word = discharging ? raw.tte_now : WORD_INVALID; // R14
			end
			CMD_TTE_AVG: begin
				cmd_word = raw.mean_current[15] ? raw.tte_avg : WORD_INVALID; // R15
			end
			CMD_TTF_AVG: begin
				cmd_word = (~raw.mean_current[15] && raw.mean_current != WORD_ZERO) ?
					raw.ttf_avg : WORD_INVALID; // R16
			end
			CMD_CHG_CURR: begin
				cmd_word = raw.chg_current; // R17
			end
			CMD_CHG_VOLT: begin
				cmd_word = raw.chg_voltage; // R18
			end
			CMD_STATUS: begin
				cmd_word = st_word; // R19 R20
			end
			CMD_CYCLES: begin
				cmd_word = s.cycles; // R22
			end
			default: begin
				cmd_known = 1'b0; // R24
			end
		endcase
	end

	// next state of the whole block
	always_comb begin
		next_s = s;
		next_s.scl_m = smbc_in;
		next_s.scl_s = s.scl_m;
		next_s.scl_q = s.scl_s;
		next_s.sda_m = smbd_in;
		next_s.sda_s = s.sda_m;
		next_s.sda_q = s.sda_s;
		next_s.cap_store = 1'b0;
		next_s.cyc_store = 1'b0;
		next_s.chg_send = 1'b0;

		// smbus read-word slave, data changes on falling clock
		// a stop ends the frame and drops any pending command
		if (bus_stop) begin
			next_s.phase = PH_IDLE;
			next_s.drive = 1'b0;
			next_s.cmd_ok = 1'b0;
		end else if (bus_start) begin
			// after an acked command a repeated start expects the read address
			next_s.phase = PH_RX;
			next_s.idx = s.cmd_ok ? IDX_ADDR_RD : IDX_ADDR_WR;
			next_s.cnt = 4'h0;
			next_s.drive = 1'b0;
		end else begin
			unique case (s.phase)
				PH_IDLE: begin
					next_s.drive = 1'b0;
				end
				// shift one bit in on each synced rising clock
				PH_RX: begin
					if (scl_rise) begin
						next_s.shreg = {s.shreg[6:0], s.sda_s};
						next_s.cnt = s.cnt + 4'h1;
					end else if (scl_fall && s.cnt == BITS_PER_BYTE) begin
						next_s.phase = PH_IDLE; // R24
						next_s.cmd_ok = 1'b0;
						if (s.idx == IDX_ADDR_WR && s.shreg == {SLAVE_ADDR, 1'b0}) begin
							next_s.phase = PH_SLV_ACK;
							next_s.drive = 1'b1;
						end else if (s.idx == IDX_CMD && cmd_known) begin
							next_s.phase = PH_SLV_ACK; // R24
							next_s.drive = 1'b1;
							next_s.word = cmd_word;
						end else if (s.idx == IDX_ADDR_RD && s.shreg == {SLAVE_ADDR, 1'b1}) begin
							next_s.phase = PH_SLV_ACK;
							next_s.drive = 1'b1;
						end
					end
				end
				// hold the acknowledge for one clock low-to-low period
				PH_SLV_ACK: begin
					if (scl_fall) begin
						next_s.cnt = 4'h0;
						next_s.drive = 1'b0;
						if (s.idx == IDX_ADDR_WR) begin
							next_s.phase = PH_RX;
							next_s.idx = IDX_CMD;
						end else if (s.idx == IDX_CMD) begin
							next_s.phase = PH_IDLE;
							next_s.cmd_ok = 1'b1;
						end else begin
							next_s.phase = PH_TX; // R24
							next_s.idx = IDX_LOW;
							next_s.shreg = s.word[7:0];
							next_s.drive = ~s.word[7];
						end
					end
				end
				// put one data bit out at each synced falling clock
				PH_TX: begin
					if (scl_fall) begin
						if (s.cnt == LAST_BIT) begin
							next_s.phase = PH_HOST_ACK;
							next_s.drive = 1'b0;
						end else begin
							next_s.shreg = {s.shreg[6:0], 1'b0};
							next_s.drive = ~s.shreg[6];
							next_s.cnt = s.cnt + 4'h1;
						end
					end
				end
				// host acknowledge asks for the high byte, a nack ends
				PH_HOST_ACK: begin
					if (scl_rise) begin
						next_s.mack = ~s.sda_s;
					end else if (scl_fall) begin
						next_s.cnt = 4'h0;
						if (s.mack && s.idx == IDX_LOW) begin
							next_s.phase = PH_TX; // R24
							next_s.idx = IDX_HIGH;
							next_s.shreg = s.word[15:8];
							next_s.drive = ~s.word[15];
						end else begin
							next_s.phase = PH_IDLE;
							next_s.cmd_ok = 1'b0;
						end
					end
				end
			endcase
		end

		// first minute before the mean current means anything
		// the counter stops once set, so it can never wrap back
		if (!s.avg_ok) begin
			next_s.up_cnt = s.up_cnt + SETTLE_W'(1);
			next_s.avg_ok = (s.up_cnt >= AVG_SETTLE_CYCLES - SETTLE_W'(1)); // R8
		end

		// learned full capacity replaces the eeprom value
		if (learn_valid) begin
			next_s.learned = 1'b1;
			next_s.learned_cap = learn_value;
			next_s.cap_store = 1'b1; // R13
		end

		// cycle counting against the last end-of-charge level
		if (charge_end) begin
			next_s.base_pct = raw.pct_full[7:0];
			next_s.armed = 1'b0;
		end else if (drop_level <= base_level && s.base_pct >= CYCLE_DROP_PCT) begin
			next_s.armed = 1'b1; // R21
		end
		// one count per discharge: the base is dropped so the arm cannot refire
		if (ee_cycle_load) begin
			next_s.cycles = ee_cycle_value;
		end else if (s.armed && charging) begin
			next_s.armed = 1'b0;
			if (!charge_end) begin
				next_s.base_pct = 8'h00; // R21
			end
			if (s.cycles != WORD_INVALID) begin
				next_s.cycles = s.cycles + 16'h0001; // R22
			end
			next_s.cyc_store = 1'b1; // R22
		end

		// charger requests sent on change while broadcasting
		// only changes are sent, so the charger is not flooded
		if (broadcast_enable &&
				(raw.chg_current != s.last_ichg || raw.chg_voltage != s.last_vchg)) begin
			next_s.last_ichg = raw.chg_current; // R17
			next_s.last_vchg = raw.chg_voltage; // R18
			next_s.chg_send = 1'b1;
		end

		// flag bytes with reserved bits zero
		// registered so the bytes stay clean data outputs
		next_s.upper = {flags_in.display_select_flag, flags_in.protector_state_flag, // R23
			flags_in.cell_type_flag, flags_in.termination_capacity_flag, 1'b0,
			flags_in.high_pack_voltage_flag, flags_in.cold_fault_flag,
			flags_in.excess_charge_current_flag};
		next_s.lower = {flags_in.temp_rate_term_flag, flags_in.taper_term_flag, // R23
			flags_in.charge_qualify_flag, 1'b0, flags_in.discharge_qualify_flag,
			flags_in.overload_flag, flags_in.first_end_discharge_flag,
			flags_in.final_end_discharge_flag};
		next_s.pct_valid = (cap_full > CAP_LOW_MAH) && (cap_full < CAP_HIGH_MAH); // R10
	end

	// state register
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// outputs straight from state or tied low, except capacity_when_full which passes raw.eeprom_full_cap until learned
	assign smbd_out = 1'b0;
	assign smbd_oe = s.drive;
	assign ee_capacity_store = s.cap_store;
	assign ee_cycle_store = s.cyc_store;
	assign capacity_when_full = cap_full; // R13
	assign cycle_counter = s.cycles;
	assign charger_send = s.chg_send;
	assign charger_current = s.last_ichg;
	assign charger_voltage = s.last_vchg;
	assign upper_flag_byte = s.upper;
	assign lower_flag_byte = s.lower;
	assign pct_valid = s.pct_valid;
	assign mean_current_valid = s.avg_ok;
endmodule
`default_nettype wire

// File: bench/bgw_readout_properties.sv
`default_nettype none
module bgw_readout_properties
	import bgw_pkg::*;
#(
	parameter logic [SETTLE_W-1:0] AVG_SETTLE_CYCLES = SETTLE_W'(1)
) (
	// clock, reset, bus
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic smbc_in,
	input wire logic smbd_oe,
	// gauge side
	input wire bgw_flags_t flags_in,
	input wire logic learn_valid,
	input wire logic [15:0] learn_value,
	input wire logic ee_cycle_load,
	input wire logic ee_capacity_store,
	input wire logic ee_cycle_store,
	input wire logic [15:0] capacity_when_full,
	input wire logic [15:0] cycle_counter,
	input wire logic broadcast_enable,
	input wire logic charger_send,
	input wire logic [7:0] upper_flag_byte,
	input wire logic [7:0] lower_flag_byte,
	input wire logic pct_valid,
	input wire logic mean_current_valid
);
	timeunit 1ns;
	timeprecision 100ps;
	// cycles since reset release
	logic [SETTLE_W-1:0] up;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			up <= '0;
		else
			up <= up + SETTLE_W'(1);
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	property p_cap_store;
		learn_valid |=> ee_capacity_store;
	endproperty
	a_cap_store: assert property (p_cap_store) else $error("no capacity store");
	property p_cap_value;
		learn_valid |=> capacity_when_full == $past(learn_value);
	endproperty
	a_cap_value: assert property (p_cap_value) else $error("capacity not learned");
	property p_cyc_step;
		!$past(ee_cycle_load) && cycle_counter != $past(cycle_counter)
			|-> cycle_counter == $past(cycle_counter) + 16'h1 && $past(cycle_counter) != 16'hffff;
	endproperty
	a_cyc_step: assert property (p_cyc_step) else $error("bad cycle step");
	property p_cyc_store;
		!$past(ee_cycle_load) && cycle_counter != $past(cycle_counter) |-> ee_cycle_store;
	endproperty
	a_cyc_store: assert property (p_cyc_store) else $error("count moved without store");
	property p_upper;
		1'b1 |=> upper_flag_byte == {$past(flags_in[13:10]), 1'b0, $past(flags_in[9:7])};
	endproperty
	a_upper: assert property (p_upper) else $error("upper flag byte");
	property p_lower;
		1'b1 |=> lower_flag_byte == {$past(flags_in[6:4]), 1'b0, $past(flags_in[3:0])};
	endproperty
	a_lower: assert property (p_lower) else $error("lower flag byte");
	property p_pct;
		1'b1 |=> pct_valid == ($past(capacity_when_full) > CAP_LOW_MAH
			&& $past(capacity_when_full) < CAP_HIGH_MAH);
	endproperty
	a_pct: assert property (p_pct) else $error("percent validity");
	property p_oe_scl;
		$changed(smbd_oe) |-> !smbc_in;
	endproperty
	a_oe_scl: assert property (p_oe_scl) else $error("data moved with clock high");
	property p_send;
		charger_send |-> $past(broadcast_enable);
	endproperty
	a_send: assert property (p_send) else $error("send while disabled");
	property p_mean;
		mean_current_valid == (up >= AVG_SETTLE_CYCLES);
	endproperty
	a_mean: assert property (p_mean) else $error("mean valid too early");
	c_learn: cover property (learn_valid ##1 ee_capacity_store);
	c_send: cover property (charger_send);
	c_ack: cover property ($rose(smbd_oe));
	c_cycle: cover property (ee_cycle_store);
endmodule
bind bgw_readout bgw_readout_properties #(.AVG_SETTLE_CYCLES(AVG_SETTLE_CYCLES)) i_props (
	.ref_clk, .rst, .smbc_in, .smbd_oe, .flags_in, .learn_valid, .learn_value,
	.ee_cycle_load, .ee_capacity_store, .ee_cycle_store, .capacity_when_full, .cycle_counter,
	.broadcast_enable, .charger_send, .upper_flag_byte, .lower_flag_byte, .pct_valid,
	.mean_current_valid
);
`default_nettype wire

// File: bench/bgw_host.sv
`default_nettype none
module bgw_host
	import bgw_pkg::*;
(
	// clock and bus lines
	input wire logic ref_clk,
	input wire logic sda_w,
	output logic scl,
	output logic sda
);
	timeunit 1ns;
	timeprecision 100ps;
	// address the host calls, moved away to test refusal
	logic [6:0] addr;
	// lines released, clock still between frames
	initial begin
		scl = 1'b1;
		sda = 1'b1;
		addr = SLAVE_ADDR;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	// data moves only while clock low
	task automatic bitx(input logic b, output logic r);
		wt(2);
		sda = b;
		wt(6);
		scl = 1'b1;
		wt(4);
		r = sda_w;
		wt(4);
		scl = 1'b0;
	endtask
	task automatic start_c;
		sda = 1'b1;
		wt(8);
		scl = 1'b1;
		wt(8);
		sda = 1'b0;
		wt(8);
		scl = 1'b0;
	endtask
	task automatic stop_c;
		wt(2);
		sda = 1'b0;
		wt(6);
		scl = 1'b1;
		wt(8);
		sda = 1'b1;
		wt(8);
	endtask
	task automatic tx(input logic [7:0] v, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bitx(v[i], r);
		bitx(1'b1, r);
		ack = !r;
	endtask
	task automatic rx(input logic last, output logic [7:0] v);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitx(1'b1, r);
			v[i] = r;
		end
		bitx(last, r);
	endtask
	// read word: command, repeated start, low byte then high byte
	task automatic rd(input logic [7:0] cmd, output logic [15:0] w, output logic ok);
		logic a;
		w = 16'h0;
		start_c;
		tx({addr, 1'b0}, ok);
		if (ok) begin
			tx(cmd, a);
			ok = a;
		end
		if (ok) begin
			start_c;
			tx({addr, 1'b1}, a);
			ok = a;
		end
		if (ok) begin
			rx(1'b0, w[7:0]);
			rx(1'b1, w[15:8]);
		end
		stop_c;
	endtask
endmodule
`default_nettype wire

// File: bench/bgw_readout_tb.sv
`default_nettype none
module bgw_readout_tb
	import bgw_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int SETTLE = 3000;
	// clock, reset, bus
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic smbc_in, smbd_in, smbd_out, smbd_oe, sda_h;
	// gauge side
	bgw_raw_t raw;
	bgw_status_t status_in;
	bgw_flags_t flags_in;
	logic learn_valid, ee_cycle_load, charge_end, broadcast_enable;
	logic ee_capacity_store, ee_cycle_store, charger_send, pct_valid, mean_current_valid;
	logic [15:0] learn_value, ee_cycle_value, capacity_when_full, cycle_counter;
	logic [15:0] charger_current, charger_voltage;
	logic [7:0] upper_flag_byte, lower_flag_byte;
	// model state and counters
	logic [15:0] m_cap, m_cyc;
	logic m_learn;
	logic [15:0] lims [4] = '{16'h05e0, 16'h05e1, 16'h289f, 16'h28a0};
	int err_total = 0;
	int compares = 0;
	int cyc = 0;

	always #5 ref_clk = ~ref_clk;
	// open-drain data wire with pull-up
	assign smbd_in = (smbd_oe ? smbd_out : 1'b1) & sda_h;

	bgw_readout #(.AVG_SETTLE_CYCLES(SETTLE_W'(SETTLE))) i_dut (
		.ref_clk, .rst, .smbc_in, .smbd_in, .smbd_out, .smbd_oe, .raw, .status_in, .flags_in,
		.learn_valid, .learn_value, .ee_cycle_load, .ee_cycle_value, .charge_end,
		.ee_capacity_store, .ee_cycle_store, .capacity_when_full, .cycle_counter,
		.broadcast_enable, .charger_send, .charger_current, .charger_voltage,
		.upper_flag_byte, .lower_flag_byte, .pct_valid, .mean_current_valid
	);
	bgw_host i_host (.ref_clk, .sda_w(smbd_in), .scl(smbc_in), .sda(sda_h));

	task automatic report_and_stop;
		if (err_total == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// cycle ceiling against hangs
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 80000) begin
			err_total++;
			report_and_stop;
		end
	end
	task automatic step(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	// expected word per command
	function automatic logic [15:0] expw(input logic [7:0] c);
		int tr, cu, mn;
		tr = $signed(raw.target_rate);
		cu = $signed(raw.current);
		mn = $signed(raw.mean_current);
		case (c)
			8'h05: return tr < 0 ? 16'hffff : raw.rate_ttf;
			8'h06: return tr < 0 ? raw.rate_tte : 16'hffff;
			8'h07: return flags_in.final_end_discharge_flag ? 16'h0000 : 16'h0001;
			8'h08: return raw.temperature;
			8'h09: return raw.voltage;
			8'h0a: return raw.current;
			8'h0b: return cyc > SETTLE + 50 ? raw.mean_current : 16'h0000;
			8'h0c: return raw.error_pct > 16'h0064 ? 16'h0064 : raw.error_pct;
			8'h0d: return raw.pct_full > 16'h0064 ? 16'h0064 : raw.pct_full;
			8'h0e: return raw.pct_design;
			8'h0f: return raw.capacity_left;
			8'h10: return m_learn ? m_cap : raw.eeprom_full_cap;
			8'h11: return cu < 0 ? raw.tte_now : 16'hffff;
			8'h12: return mn < 0 ? raw.tte_avg : 16'hffff;
			8'h13: return mn > 0 ? raw.ttf_avg : 16'hffff;
			8'h14: return raw.chg_current;
			8'h15: return raw.chg_voltage;
			8'h16: return status_in & 16'hdbff;
			default: return m_cyc;
		endcase
	endfunction
	task automatic rdc(input logic [7:0] c, input logic ack_exp);
		logic [15:0] w;
		logic ok;
		i_host.rd(c, w, ok);
		chk("ack", {15'h0, ok}, {15'h0, ack_exp});
		if (ack_exp)
			chk($sformatf("cmd %h", c), w, expw(c));
	endtask
	// main sequence
	initial begin
		raw = '0;
		status_in = '0;
		flags_in = '0;
		{learn_valid, ee_cycle_load, charge_end, broadcast_enable} = 4'h0;
		learn_value = 16'h0;
		ee_cycle_value = 16'h0;
		{m_cap, m_cyc, m_learn} = '0;
		void'($urandom(32'hccb7));
		step(16);
		rst = 1'b0;
		step(4);
		rdc(8'h0b, 1'b1);
		chk("mean_valid", {15'h0, mean_current_valid}, 16'h0);
		rdc(8'h04, 1'b0);
		rdc(8'h18, 1'b0);
		// a foreign address is never acknowledged
		i_host.addr = SLAVE_ADDR ^ 7'h01;
		rdc(8'h08, 1'b0);
		i_host.addr = SLAVE_ADDR;
		foreach (lims[i]) begin
			raw.eeprom_full_cap = lims[i];
			step(3);
			chk("pct_valid", {15'h0, pct_valid},
				{15'h0, lims[i] > CAP_LOW_MAH && lims[i] < CAP_HIGH_MAH});
		end
		while (cyc < SETTLE + 100)
			step(1);
		chk("mean_valid", {15'h0, mean_current_valid}, 16'h1);
		for (int r = 0; r < 3; r++) begin
			for (int k = 0; k < 17; k++)
				raw[k*16 +: 16] = 16'($urandom);
			raw.error_pct = 16'($urandom_range(120));
			raw.pct_full = 16'($urandom_range(120));
			status_in = 16'($urandom);
			flags_in = 14'($urandom);
			broadcast_enable = 1'($urandom);
			if (r == 2) begin
				learn_value = 16'($urandom);
				learn_valid = 1'b1;
				step(1);
				learn_valid = 1'b0;
				chk("cap_store", {15'h0, ee_capacity_store}, 16'h1);
				{m_learn, m_cap} = {1'b1, learn_value};
				step(1);
				chk("cap_full", capacity_when_full, m_cap);
			end
			for (int c = 5; c < 24; c++)
				rdc(8'(c), 1'b1);
			chk("upper", upper_flag_byte, {flags_in[13:10], 1'b0, flags_in[9:7]});
			chk("lower", lower_flag_byte, {flags_in[6:4], 1'b0, flags_in[3:0]});
		end
		// changed requests go to the charger
		broadcast_enable = 1'b1;
		raw.chg_current = raw.chg_current + 16'h1;
		raw.chg_voltage = raw.chg_voltage ^ 16'h0101;
		for (int t = 0; t < 8 && charger_send !== 1'b1; t++)
			step(1);
		chk("send", {15'h0, charger_send}, 16'h1);
		chk("chg_i", charger_current, raw.chg_current);
		chk("chg_v", charger_voltage, raw.chg_voltage);
		// cycle count at the drop boundary, once per discharge, then saturation
		ee_cycle_value = 16'hfffd;
		ee_cycle_load = 1'b1;
		step(1);
		ee_cycle_load = 1'b0;
		m_cyc = 16'hfffd;
		raw.current = 16'h0100;
		for (int n = 0; n < 3; n++) begin
			raw.pct_full = 16'h0032;
			charge_end = 1'b1;
			step(1);
			charge_end = 1'b0;
			raw.pct_full = 16'h0024;
			step(6);
			chk("cycles", cycle_counter, m_cyc);
			raw.pct_full = 16'h0023;
			step(2);
			chk("cyc_store", {15'h0, ee_cycle_store}, 16'h1);
			step(6);
			if (m_cyc != 16'hffff)
				m_cyc = m_cyc + 16'h1;
			chk("cycles", cycle_counter, m_cyc);
		end
		rdc(8'h17, 1'b1);
		report_and_stop;
	end
endmodule
`default_nettype wire
